// ### verilog/wdwr_pkg.sv
// Constants, carrier types and decode helpers for the watchdog and wake-up block.
package wdwr_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_WDOG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_RST_FLAGS = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_WAKE_EN = 8'h0C;

  // ----------------------------------------------------------------------
  // Field layouts and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] WDOG_CTRL_POR = 8'h53;
  localparam int KEY_LSB = 3;
  localparam int KEY_W = 5;
  localparam int SEL_W = 3;
  localparam logic [KEY_W-1:0] KEY_ENABLE = 5'h0A;
  localparam logic [KEY_W-1:0] KEY_DISABLE = 5'h15;
  localparam int WRF_BIT = 0;
  localparam int PDF_BIT = 0;
  localparam int TO_BIT = 1;
  localparam int HALT_BIT = 2;
  localparam logic [7:0] RST_FLAGS_POR = 8'h00;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_FREQ_HZ = 20_000_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_FREQ_HZ;
  localparam int SLOW_OSC_HZ = 32_000;
  localparam int SW_RST_DELAY_NS = 1000;
  localparam int SW_RST_DELAY_CYC = (SW_RST_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLY_W = $clog2(SW_RST_DELAY_CYC + 1);
  localparam int WDOG_CNT_W = 19;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_HALT = 3'b010,
    ST_KEYRST = 3'b100
  } wdwr_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } wdwr_apb_req_t;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } wdwr_apb_rsp_t;

  typedef struct packed {
    logic resume;
    logic irq_service;
    logic warm_reset;
  } wdwr_wake_t;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [4:0] wdwr_period_bit(input logic [SEL_W-1:0] sel);
    case (sel)
      3'h0: wdwr_period_bit = 5'h08;
      3'h1: wdwr_period_bit = 5'h0A;
      3'h2: wdwr_period_bit = 5'h0C;
      3'h3: wdwr_period_bit = 5'h0E;
      3'h4: wdwr_period_bit = 5'h0F;
      3'h5: wdwr_period_bit = 5'h10;
      3'h6: wdwr_period_bit = 5'h11;
      default: wdwr_period_bit = 5'h12;
    endcase
  endfunction

  function automatic logic wdwr_key_valid(input logic [KEY_W-1:0] key);
    wdwr_key_valid = (key == KEY_ENABLE) || (key == KEY_DISABLE);
  endfunction

endpackage

// ### verilog/wdwr_top.sv
// Watchdog timer, reset-cause flags and low-power wake-up logic with an APB register port.
`timescale 1ns/1ps

module wdwr_top
  import wdwr_pkg::*;
#(
  parameter int PA_W = 8,
  parameter int IRQ_N = 8
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire wdwr_apb_req_t apb_req_i,
  output wdwr_apb_rsp_t apb_rsp_o,
  input wire logic slow_internal_osc_i,
  input wire logic halt_exec_i,
  input wire logic clear_watchdog_instruction_i,
  input wire logic [PA_W-1:0] port_a_i,
  input wire logic [IRQ_N-1:0] irq_req_i,
  input wire logic [IRQ_N-1:0] irq_en_i,
  input wire logic stack_full_i,
  output logic halted_o,
  output wdwr_wake_t wake_o,
  output logic full_reset_o,
  output logic power_on_init_o
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  if (PA_W < 1 || PA_W > 32) begin : g_bad_pa
    $error("PA_W must lie between 1 and 32");
  end
  if (IRQ_N < 1) begin : g_bad_irq
    $error("IRQ_N must be at least 1");
  end
  // The counter must reach the highest selectable period bit, or the longest timeout never fires.
  if (WDOG_CNT_W <= int'(wdwr_period_bit({SEL_W{1'b1}}))) begin : g_bad_cnt
    $error("WDOG_CNT_W is too narrow for the longest period");
  end
  if (SW_RST_DELAY_CYC < 1 || SW_RST_DELAY_CYC >= (1 << DLY_W)) begin : g_bad_dly
    $error("Software-reset delay does not fit its counter");
  end
  if (KEY_LSB + KEY_W > 8 || SEL_W > KEY_LSB) begin : g_bad_ctrl
    $error("Control register fields overlap or overflow");
  end
  // Every register takes one aligned word; a misaligned offset would alias two registers.
  if (OFF_WDOG_CTRL[1:0] != 2'b00 || OFF_RST_FLAGS[1:0] != 2'b00 ||
      OFF_STATUS[1:0] != 2'b00 || OFF_WAKE_EN[1:0] != 2'b00) begin : g_bad_align
    $error("Register offsets must be word aligned");
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Address decode is shared by the read path and by every write strobe.
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] off);
    reg_hit = (addr == off);
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    wdwr_state_t st;
    logic [7:0] wdog_ctrl;
    logic key_rst_flag;
    logic powerdown_flag;
    logic to;
    logic [PA_W-1:0] wake_en;
    logic [WDOG_CNT_W-1:0] cnt;
    logic osc_q;
    logic [PA_W-1:0] pa_q;
    logic [IRQ_N-1:0] irq_arm;
    logic [DLY_W-1:0] dly;
    logic [31:0] rdata;
    logic slverr;
    wdwr_wake_t wake;
    logic full_rst;
    logic por;
  } wdwr_regs_t;

  wdwr_regs_t s_r;
  wdwr_regs_t s_nxt;

  // ----------------------------------------------------------------------
  // Control decode
  // ----------------------------------------------------------------------
  logic [KEY_W-1:0] key;
  logic [SEL_W-1:0] sel;
  logic wdog_on;
  logic osc_rise;
  logic [(1 << SEL_W)-1:0] period_tap;
  logic overflow;
  logic expire;
  logic [WDOG_CNT_W-1:0] cnt_inc;

  assign key = s_r.wdog_ctrl[KEY_LSB +: KEY_W];
  assign sel = s_r.wdog_ctrl[SEL_W-1:0];
  assign wdog_on = (key == KEY_ENABLE);
  assign osc_rise = slow_internal_osc_i & ~s_r.osc_q;
  // One tap per period code; the select only steers a mux, so a change of period never glitches the count.
  for (genvar k = 0; k < (1 << SEL_W); k++) begin : g_period_tap
    assign period_tap[k] = s_r.cnt[wdwr_period_bit(SEL_W'(k))];
  end
  assign overflow = period_tap[sel];
  assign expire = wdog_on & overflow;
  assign cnt_inc = s_r.cnt + {{(WDOG_CNT_W-1){1'b0}}, 1'b1};

  // ----------------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------------
  logic setup;
  logic access;
  logic hit_ctrl;
  logic hit_flags;
  logic hit_stat;
  logic hit_wake;
  logic wr_any;
  logic wr_ctrl;
  logic wr_flags;
  logic wr_wake;
  logic key_bad;

  assign setup = apb_req_i.psel & ~apb_req_i.penable;
  assign access = apb_req_i.psel & apb_req_i.penable;
  assign hit_ctrl = reg_hit(apb_req_i.paddr, OFF_WDOG_CTRL);
  assign hit_flags = reg_hit(apb_req_i.paddr, OFF_RST_FLAGS);
  assign hit_stat = reg_hit(apb_req_i.paddr, OFF_STATUS);
  assign hit_wake = reg_hit(apb_req_i.paddr, OFF_WAKE_EN);
  assign wr_any = access & apb_req_i.pwrite;
  assign wr_ctrl = wr_any & hit_ctrl;
  assign wr_flags = wr_any & hit_flags;
  assign wr_wake = wr_any & hit_wake;
  assign key_bad = ~wdwr_key_valid(apb_req_i.pwdata[KEY_LSB +: KEY_W]);

  // ----------------------------------------------------------------------
  // Wake sources
  // ----------------------------------------------------------------------
  logic in_halt;
  logic dly_done;
  logic [PA_W-1:0] pa_fall;
  logic [IRQ_N-1:0] irq_wake;
  logic [IRQ_N-1:0] irq_serve;
  logic wake_irq;
  logic wake_pin;

  assign in_halt = (s_r.st == ST_HALT);
  assign dly_done = (s_r.st == ST_KEYRST) && (s_r.dly == '0);
  // One falling-edge detector per pin; a pin whose wake enable is clear never wakes the device.
  for (genvar i = 0; i < PA_W; i++) begin : g_pin_wake
    assign pa_fall[i] = s_r.pa_q[i] & ~port_a_i[i] & s_r.wake_en[i];
  end
  // A request that was already high when the halt was taken stays disarmed until the next halt.
  for (genvar j = 0; j < IRQ_N; j++) begin : g_irq_wake
    assign irq_wake[j] = irq_req_i[j] & s_r.irq_arm[j];
    assign irq_serve[j] = irq_wake[j] & irq_en_i[j];
  end
  assign wake_irq = |irq_wake;
  assign wake_pin = |pa_fall;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.osc_q = slow_internal_osc_i;
    s_nxt.pa_q = port_a_i;
    s_nxt.wake = '0;
    s_nxt.full_rst = 1'b0;
    s_nxt.por = 1'b0;

    // ------------------------------------------------------------------
    // Watchdog counter
    // ------------------------------------------------------------------
    // The count advances only on slow-oscillator edges, so the fast clock never shortens a period.
    if (wdog_on && osc_rise && !overflow) begin
      s_nxt.cnt = cnt_inc;
    end

    // ------------------------------------------------------------------
    // Halt and wake sequencing
    // ------------------------------------------------------------------
    // Overflow outranks halt, so a halt issued too late cannot hide a runaway program.
    case (s_r.st)
      ST_RUN: begin
        if (expire) begin
          s_nxt.to = 1'b1;
          s_nxt.full_rst = 1'b1;
          s_nxt.cnt = '0;
        end else if (halt_exec_i) begin
          s_nxt.st = ST_HALT;
          s_nxt.powerdown_flag = 1'b1;
          s_nxt.to = 1'b0;
          s_nxt.cnt = '0;
          s_nxt.irq_arm = ~irq_req_i;
        end else if (clear_watchdog_instruction_i) begin
          s_nxt.cnt = '0;
          s_nxt.powerdown_flag = 1'b0;
        end
      end

      ST_HALT: begin
        if (expire) begin
          s_nxt.st = ST_RUN;
          s_nxt.to = 1'b1;
          s_nxt.powerdown_flag = 1'b1;
          s_nxt.wake.warm_reset = 1'b1;
          s_nxt.cnt = '0;
        end else if (wake_irq) begin
          s_nxt.st = ST_RUN;
          if (|irq_serve && !stack_full_i) begin
            s_nxt.wake.irq_service = 1'b1;
          end else begin
            s_nxt.wake.resume = 1'b1;
          end
        end else if (wake_pin) begin
          s_nxt.st = ST_RUN;
          s_nxt.wake.resume = 1'b1;
        end
      end

      ST_KEYRST: begin
        s_nxt.cnt = '0;
        if (dly_done) begin
          s_nxt.st = ST_RUN;
          s_nxt.full_rst = 1'b1;
          s_nxt.wdog_ctrl = WDOG_CTRL_POR;
        end else begin
          s_nxt.dly = s_r.dly - {{(DLY_W-1){1'b0}}, 1'b1};
        end
      end

      default: begin
        s_nxt.st = ST_RUN;
      end
    endcase

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Read data is captured in the setup cycle so the zero-wait access phase sees a flop.
    if (setup) begin
      s_nxt.slverr = 1'b0;
      s_nxt.rdata = '0;
      if (hit_ctrl) begin
        s_nxt.rdata[7:0] = s_r.wdog_ctrl;
      end else if (hit_flags) begin
        s_nxt.rdata[WRF_BIT] = s_r.key_rst_flag;
      end else if (hit_stat) begin
        s_nxt.rdata[PDF_BIT] = s_r.powerdown_flag;
        s_nxt.rdata[TO_BIT] = s_r.to;
        s_nxt.rdata[HALT_BIT] = in_halt;
      end else if (hit_wake) begin
        s_nxt.rdata[PA_W-1:0] = s_r.wake_en;
      end else begin
        s_nxt.slverr = 1'b1;
      end
    end

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    // Status is read-only; a write to it completes without effect.
    if (wr_wake) begin
      s_nxt.wake_en = apb_req_i.pwdata[PA_W-1:0];
    end
    // A control write while the key-reset delay runs is ignored; the reset is already committed.
    if (wr_ctrl && s_r.st != ST_KEYRST) begin
      s_nxt.wdog_ctrl = apb_req_i.pwdata[7:0];
      if (key_bad) begin
        s_nxt.st = ST_KEYRST;
        s_nxt.dly = DLY_W'(SW_RST_DELAY_CYC - 1);
        s_nxt.cnt = '0;
      end
    end

    // ------------------------------------------------------------------
    // Reset-cause flag
    // ------------------------------------------------------------------
    if (wr_flags && !apb_req_i.pwdata[WRF_BIT]) begin
      s_nxt.key_rst_flag = 1'b0;
    end
    // The hardware set is applied last so that it wins over a software clear in the same cycle.
    if (dly_done) begin
      s_nxt.key_rst_flag = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Of the two resets only this one clears the timeout and key flags (halt entry also clears the timeout); the full-reset request leaves them.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_r.st <= ST_RUN;
      s_r.wdog_ctrl <= WDOG_CTRL_POR;
      s_r.key_rst_flag <= RST_FLAGS_POR[WRF_BIT];
      s_r.powerdown_flag <= 1'b0;
      s_r.to <= 1'b0;
      s_r.wake_en <= '0;
      s_r.cnt <= '0;
      s_r.osc_q <= 1'b0;
      s_r.pa_q <= '0;
      s_r.irq_arm <= '0;
      s_r.dly <= '0;
      s_r.rdata <= '0;
      s_r.slverr <= 1'b0;
      s_r.wake <= '0;
      s_r.full_rst <= 1'b0;
      s_r.por <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // The slave never stretches a transfer, so every access ends at its first access edge.
  assign apb_rsp_o.pready = 1'b1;
  assign apb_rsp_o.prdata = s_r.rdata;
  assign apb_rsp_o.pslverr = s_r.slverr & access;
  assign halted_o = in_halt;
  assign wake_o = s_r.wake;
  assign full_reset_o = s_r.full_rst;
  // The core clears its program counter and sets port data and direction to ones on this level.
  assign power_on_init_o = s_r.por | srst_i;

endmodule // wdwr_top

// ### tb/wdwr_monitor.sv
// Port-level assertion checker for the watchdog and wake-up block.
`timescale 1ns/1ps
module wdwr_monitor
  import wdwr_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire wdwr_apb_req_t apb_req_i,
  input wire wdwr_apb_rsp_t apb_rsp_o,
  input wire logic halt_exec_i,
  input wire logic stack_full_i,
  input wire logic halted_o,
  input wire wdwr_wake_t wake_o,
  input wire logic full_reset_o,
  input wire logic power_on_init_o
);
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // The init strobe outlives reset by exactly one cycle.
  sequence init_tail_s;
    power_on_init_o ##1 !power_on_init_o;
  endsequence
  init_tail_a: assert property ($fell(srst_i) |-> init_tail_s) else $error("init strobe length");
  err_phase_a: assert property (apb_rsp_o.pslverr |-> apb_req_i.psel && apb_req_i.penable)
    else $error("pslverr outside access");
  halt_entry_a: assert property ($rose(halted_o) |-> $past(halt_exec_i)) else $error("halt without cause");
  wake_onehot_a: assert property ($onehot0(wake_o)) else $error("two wake causes");
  wake_exit_a: assert property ((|wake_o) |-> $past(halted_o) && !halted_o) else $error("wake while running");
  halt_exit_a: assert property ($fell(halted_o) |-> (|wake_o)) else $error("halt left silently");
  irq_room_a: assert property (wake_o.irq_service |-> !$past(stack_full_i)) else $error("service on full stack");
  reset_pulse_a: assert property (full_reset_o |=> !full_reset_o) else $error("reset pulse too long");
endmodule // wdwr_monitor

bind wdwr_top wdwr_monitor mon_u (.clk_i(clk_i), .srst_i(srst_i), .apb_req_i(apb_req_i), .apb_rsp_o(apb_rsp_o),
  .halt_exec_i(halt_exec_i), .stack_full_i(stack_full_i), .halted_o(halted_o), .wake_o(wake_o),
  .full_reset_o(full_reset_o), .power_on_init_o(power_on_init_o));

// ### tb/test_watchdog_wakeup_reset_flags.sv
// Self-checking testbench for the watchdog and wake-up block.
`timescale 1ns/1ps
module test_watchdog_wakeup_reset_flags;
  import wdwr_pkg::*;
  // ----------------------------------------------------------------------
  // Stimulus and pulse counters
  // ----------------------------------------------------------------------
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  wdwr_apb_req_t req = '0;
  wdwr_apb_rsp_t rsp;
  logic osc = 1'b0, halt = 1'b0, clrw = 1'b0, sfull = 1'b0, halted, frst, poi, err;
  logic [7:0] pa = 8'hFF, irq = 8'h00, ien = 8'h03;
  logic [31:0] rd;
  wdwr_wake_t wake;
  int error_cnt = 0, tests_run = 0, frst_n = 0, res_n = 0, svc_n = 0, warm_n = 0;

  wdwr_top dut_u (.clk_i(clk_i), .srst_i(srst_i), .apb_req_i(req), .apb_rsp_o(rsp), .slow_internal_osc_i(osc),
    .halt_exec_i(halt), .clear_watchdog_instruction_i(clrw), .port_a_i(pa), .irq_req_i(irq), .irq_en_i(ien),
    .stack_full_i(sfull), .halted_o(halted), .wake_o(wake), .full_reset_o(frst), .power_on_init_o(poi));

  initial forever #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    frst_n += (frst === 1'b1);
    res_n += (wake.resume === 1'b1);
    svc_n += (wake.irq_service === 1'b1);
    warm_n += (wake.warm_reset === 1'b1);
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Holds the request until pready is seen high; only the watchdog process ends a wait.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    req.psel <= 1'b1;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= wd;
    tick(1);
    req.penable <= 1'b1;
    tick(1);
    while (rsp.pready !== 1'b1) begin
      tick(1);
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    tick(1);
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask
  task automatic osc_run(input int n);
    repeat (n) begin
      osc <= 1'b1;
      tick(2);
      osc <= 1'b0;
      tick(2);
    end
  endtask
  task automatic instr(input bit h);
    if (h) halt <= 1'b1;
    else clrw <= 1'b1;
    tick(1);
    halt <= 1'b0;
    clrw <= 1'b0;
    tick(3);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // The longest path is under 6000 cycles, so 20000 means a hang.
  initial begin
    tick(20000);
    error_cnt++;
    end_of_test;
  end

  initial begin
    tick(4);
    #1 chk("init", 32'h1, poi);
    tick(4);
    srst_i <= 1'b0;
    tick(1);
    rdchk("ctrl", OFF_WDOG_CTRL, 32'h53);
    rdchk("flags", OFF_RST_FLAGS, 32'h0);
    rdchk("stat", OFF_STATUS, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    apb(1'b1, OFF_WDOG_CTRL, 32'h50);
    osc_run(255);
    chk("early", 32'h0, frst_n);
    osc_run(1);
    tick(3);
    chk("ovf", 32'h1, frst_n);
    rdchk("stat_to", OFF_STATUS, 32'h2);
    osc_run(200);
    instr(0);
    osc_run(200);
    chk("cleared", 32'h1, frst_n);
    instr(1);
    chk("halted", 32'h1, {31'h0, halted});
    rdchk("stat_halt", OFF_STATUS, 32'h5);
    apb(1'b1, OFF_WAKE_EN, 32'h1);
    pa <= 8'hFE;
    tick(3);
    pa <= 8'hFF;
    chk("pin_wake", 32'h1, res_n);
    instr(0);
    rdchk("stat_clr", OFF_STATUS, 32'h0);
    irq <= 8'h01;
    instr(1);
    chk("stale_irq", 32'h1, res_n + svc_n);
    irq <= 8'h03;
    tick(3);
    chk("irq_svc", 32'h1, svc_n);
    irq <= 8'h00;
    instr(1);
    sfull <= 1'b1;
    irq <= 8'h02;
    tick(3);
    chk("irq_res", 32'h2, res_n);
    irq <= 8'h00;
    sfull <= 1'b0;
    instr(1);
    osc_run(256);
    tick(3);
    chk("warm", 32'h1, warm_n);
    rdchk("stat_warm", OFF_STATUS, 32'h3);
    chk("no_full", 32'h1, frst_n);
    apb(1'b1, OFF_WDOG_CTRL, 32'hA8);
    osc_run(300);
    chk("off", 32'h1, frst_n);
    apb(1'b1, OFF_WDOG_CTRL, 32'h00);
    tick(15);
    chk("key_wait", 32'h1, frst_n);
    tick(8);
    chk("key_rst", 32'h2, frst_n);
    rdchk("key_flag", OFF_RST_FLAGS, 32'h1);
    rdchk("ctrl_back", OFF_WDOG_CTRL, 32'h53);
    apb(1'b1, OFF_RST_FLAGS, 32'hF1);
    rdchk("upper", OFF_RST_FLAGS, 32'h1);
    apb(1'b1, OFF_RST_FLAGS, 32'h0);
    rdchk("flag_clr", OFF_RST_FLAGS, 32'h0);
    end_of_test;
  end
endmodule // test_watchdog_wakeup_reset_flags
